// file: rtl/omg_defs.vh
// omg_defs.vh - constants of the operating-mode and pin configuration register bank
//------------------------------------------------------------
// rule summary
//------------------------------------------------------------
`ifndef OMG_DEFS_VH
`define OMG_DEFS_VH

`define OMG_ADDR_W          5
`define OMG_OFF_OPMODE      5'h04
`define OMG_OFF_FUNC        5'h05
`define OMG_OFF_DIR         5'h07
`define OMG_OFF_DRIVE       5'h09
`define OMG_OFF_LEVEL       5'h0B
`define OMG_OFF_INPUT       5'h0D
`define OMG_OFF_BLANK       5'h0F
`define OMG_OFF_STATUS      5'h18
`define OMG_RESET_VAL       8'h00

`define OMG_ERR_RESP_BIT    7
`define OMG_MODE_HI         6
`define OMG_MODE_LO         5
`define OMG_OSC_BIT         4
`define OMG_DIV_HI          3
`define OMG_DIV_LO          0
`define OMG_MODE_HOST       2'h0
`define OMG_MODE_AUTO       2'h1
`define OMG_MULT_BIT        7
`define OMG_BLANK_HI        6
`define OMG_BLANK_LO        0
`define OMG_MULT_SHIFT      3

`endif

// file: rtl/omg_pin_cell.v
// omg_pin_cell.v - one channel pin driver with readback
`timescale 1ns/10ps
`default_nettype none
module omg_pin_cell (
  input  wire i_clk,
  input  wire i_srst,
  input  wire i_digital,
  input  wire i_out_dir,
  input  wire i_push_pull,
  input  wire i_level,
  input  wire i_pin,
  output wire o_pin,
  output wire o_pin_oe,
  output reg  o_read_q
);
  //------------------------------------------------------------
  // drive logic
  //------------------------------------------------------------
  wire drives;
  assign drives = i_digital & i_out_dir;
  // open drain only pulls low; pull-up is external
  assign o_pin    = i_level;
  assign o_pin_oe = drives & (i_push_pull | ~i_level);

  // readback of the pin level, analog pins read zero
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_read_q <= 1'b0;
    end else begin
      o_read_q <= i_digital & i_pin;
    end
  end
endmodule // omg_pin_cell
`default_nettype wire

// file: rtl/omg_blank_calc.v
// omg_blank_calc.v - effective crossing blanking count
`timescale 1ns/10ps
`default_nettype none
`include "omg_defs.vh"
module omg_blank_calc (
  input  wire [7:0]  i_cfg,
  output wire [9:0]  o_count
);
  //------------------------------------------------------------
  // count selection
  //------------------------------------------------------------
  wire [9:0] field;
  assign field   = {3'h0, i_cfg[`OMG_BLANK_HI:`OMG_BLANK_LO]};
  assign o_count = i_cfg[`OMG_MULT_BIT] ? (field << `OMG_MULT_SHIFT) : field;
endmodule // omg_blank_calc
`default_nettype wire

// file: rtl/omg_regs.v
// omg_regs.v - operating-mode and pin configuration register bank
`timescale 1ns/10ps
`default_nettype none
`include "omg_defs.vh"
module omg_regs (
  input  wire                   i_clk,
  input  wire                   i_srst,
  input  wire [`OMG_ADDR_W-1:0] i_addr,
  input  wire [7:0]             i_wdata,
  input  wire                   i_wr,
  input  wire                   i_rd,
  output reg  [7:0]             o_rdata_q,
  input  wire                   i_crc_err_flag,
  input  wire                   i_force_analog_all,
  input  wire [7:0]             i_pin,
  output wire [7:0]             o_pin,
  output wire [7:0]             o_pin_oe,
  output reg  [1:0]             o_conversion_trigger_mode_q,
  output reg                    o_auto_mode_q,
  output reg                    o_oscillator_choice_q,
  output reg  [3:0]             o_clk_div_q,
  output reg                    o_seq_run_q,
  output reg  [7:0]             o_digital_q,
  output reg  [9:0]             o_blank_count_q
);
  //------------------------------------------------------------
  // stored registers
  //------------------------------------------------------------
  reg [7:0] opmode_q;
  reg [7:0] func_q;
  reg [7:0] dir_q;
  reg [7:0] drive_q;
  reg [7:0] level_q;
  reg [7:0] blank_q;
  wire [7:0] input_level;
  wire [9:0] blank_count;

  // software writes; settings are kept during an error so they can be restored
  always @(posedge i_clk) begin
    if (i_srst) begin
      opmode_q <= `OMG_RESET_VAL;
      func_q   <= `OMG_RESET_VAL;
      dir_q    <= `OMG_RESET_VAL;
      drive_q  <= `OMG_RESET_VAL;
      level_q  <= `OMG_RESET_VAL;
      blank_q  <= `OMG_RESET_VAL;
    end else if (i_wr) begin
      if (i_addr == `OMG_OFF_OPMODE) begin
        opmode_q <= i_wdata;
      end else if (i_addr == `OMG_OFF_FUNC) begin
        func_q <= i_wdata;
      end else if (i_addr == `OMG_OFF_DIR) begin
        dir_q <= i_wdata;
      end else if (i_addr == `OMG_OFF_DRIVE) begin
        drive_q <= i_wdata;
      end else if (i_addr == `OMG_OFF_LEVEL) begin
        level_q <= i_wdata;
      end else if (i_addr == `OMG_OFF_BLANK) begin
        blank_q <= i_wdata;
      end
    end
  end

  //------------------------------------------------------------
  // error response and pin override
  //------------------------------------------------------------
  wire err_hold;
  wire analog_all;
  assign err_hold   = opmode_q[`OMG_ERR_RESP_BIT] & i_crc_err_flag;
  assign analog_all = err_hold | i_force_analog_all;

  // effective state; ends on the first clock after the flag clears
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_digital_q                 <= 8'h00;
      o_seq_run_q                 <= 1'b0;
      o_conversion_trigger_mode_q <= `OMG_MODE_HOST;
      o_auto_mode_q               <= 1'b0;
      o_oscillator_choice_q       <= 1'b0;
      o_clk_div_q                 <= 4'h0;
      o_blank_count_q             <= 10'h000;
    end else begin
      o_digital_q                 <= analog_all ? 8'h00 : func_q;
      o_seq_run_q                 <= ~err_hold;
      o_conversion_trigger_mode_q <= opmode_q[`OMG_MODE_HI:`OMG_MODE_LO];
      o_auto_mode_q <= (opmode_q[`OMG_MODE_HI:`OMG_MODE_LO] == `OMG_MODE_AUTO);
      o_oscillator_choice_q       <= opmode_q[`OMG_OSC_BIT];
      o_clk_div_q                 <= opmode_q[`OMG_DIV_HI:`OMG_DIV_LO];
      o_blank_count_q             <= blank_count;
    end
  end

  //------------------------------------------------------------
  // channel pins
  //------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      omg_pin_cell u_cell (
        .i_clk       (i_clk),
        .i_srst      (i_srst),
        .i_digital   (o_digital_q[g]),
        .i_out_dir   (dir_q[g]),
        .i_push_pull (drive_q[g]),
        .i_level     (level_q[g]),
        .i_pin       (i_pin[g]),
        .o_pin       (o_pin[g]),
        .o_pin_oe    (o_pin_oe[g]),
        .o_read_q    (input_level[g])
      );
    end
  endgenerate

  omg_blank_calc u_blank (
    .i_cfg   (blank_q),
    .o_count (blank_count)
  );

  //------------------------------------------------------------
  // read path, unmapped offsets read zero
  //------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata_q <= 8'h00;
    end else if (i_rd) begin
      if (i_addr == `OMG_OFF_OPMODE) begin
        o_rdata_q <= opmode_q;
      end else if (i_addr == `OMG_OFF_FUNC) begin
        o_rdata_q <= func_q;
      end else if (i_addr == `OMG_OFF_DIR) begin
        o_rdata_q <= dir_q;
      end else if (i_addr == `OMG_OFF_DRIVE) begin
        o_rdata_q <= drive_q;
      end else if (i_addr == `OMG_OFF_LEVEL) begin
        o_rdata_q <= level_q;
      end else if (i_addr == `OMG_OFF_INPUT) begin
        o_rdata_q <= input_level;
      end else if (i_addr == `OMG_OFF_BLANK) begin
        o_rdata_q <= blank_q;
      end else if (i_addr == `OMG_OFF_STATUS) begin
        o_rdata_q <= {6'h00, err_hold, o_seq_run_q};
      end else begin
        o_rdata_q <= 8'h00;
      end
    end else begin
      o_rdata_q <= 8'h00;
    end
  end
endmodule // omg_regs
`default_nettype wire

// file: verif/omg_regs_props.sv
// omg_regs_props.sv - checker for the register bank
`timescale 1ns/10ps
`default_nettype none
module omg_regs_props (
  input wire logic       i_clk,
  input wire logic       i_srst,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata_q,
  input wire logic       i_crc_err_flag,
  input wire logic       i_force_analog_all,
  input wire logic [7:0] i_pin,
  input wire logic [7:0] o_pin,
  input wire logic [7:0] o_pin_oe,
  input wire logic [1:0] o_conversion_trigger_mode_q,
  input wire logic       o_auto_mode_q,
  input wire logic       o_oscillator_choice_q,
  input wire logic [3:0] o_clk_div_q,
  input wire logic       o_seq_run_q,
  input wire logic [7:0] o_digital_q,
  input wire logic [9:0] o_blank_count_q
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // writes reach the derived outputs two edges after being taken
  sequence s_mode_wr; i_wr && i_addr == 5'h04; endsequence
  sequence s_blank_wr; i_wr && i_addr == 5'h0F; endsequence
  chk_mode_div: assert property (s_mode_wr |-> ##2 o_clk_div_q == $past(i_wdata[3:0], 2))
    else $error("divider not taken");
  chk_mode_osc: assert property (s_mode_wr |-> ##2 o_conversion_trigger_mode_q == $past(i_wdata[6:5], 2)
    && o_oscillator_choice_q == $past(i_wdata[4], 2)) else $error("mode fields not taken");
  chk_auto_flag: assert property (o_auto_mode_q == (o_conversion_trigger_mode_q == 2'h1))
    else $error("auto flag wrong");
  chk_blank_count: assert property (s_blank_wr |-> ##2 o_blank_count_q == ($past(i_wdata[7], 2) ?
    {$past(i_wdata[6:0], 2), 3'h0} : {3'h0, $past(i_wdata[6:0], 2)})) else $error("blank count wrong");
  chk_oe_digital: assert property ((o_pin_oe & ~o_digital_q) == 8'h00)
    else $error("analog pin driven");
  chk_hold_analog: assert property ($past(i_crc_err_flag) && !o_seq_run_q |-> o_digital_q == 8'h00)
    else $error("pins kept under hold");
  chk_run_clear: assert property (!$past(i_srst) && !$past(i_crc_err_flag) |-> o_seq_run_q)
    else $error("sequencing paused without error");
  chk_force_all: assert property ($past(i_force_analog_all) |-> o_digital_q == 8'h00 && o_pin_oe == 8'h00)
    else $error("force analog ignored");
endmodule // omg_regs_props
bind omg_regs omg_regs_props i_omg_regs_props (.*);
`default_nettype wire

// file: verif/omg_pin_model.sv
// omg_pin_model.sv - board side of the eight channel pins
`timescale 1ns/10ps
`default_nettype none
module omg_pin_model (
  input  wire logic [7:0] i_level,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_ext,
  input  wire logic [7:0] i_ext_en,
  output var logic  [7:0] o_wire
);
  // device drive, else board driver, else the pull-up an open drain needs
  always_comb
    for (int g = 0; g < 8; g++)
      o_wire[g] = i_oe[g] ? i_level[g] : (i_ext_en[g] ? i_ext[g] : 1'b1);
endmodule // omg_pin_model
`default_nettype wire

// file: verif/omg_regs_tb.sv
// omg_regs_tb.sv - register access bench for the configuration bank
`timescale 1ns/10ps
`default_nettype none
module omg_regs_tb;
  logic       i_clk, i_srst, i_wr, i_rd, i_crc_err_flag, i_force_analog_all;
  logic       o_auto_mode_q, o_oscillator_choice_q, o_seq_run_q;
  logic [1:0] o_conversion_trigger_mode_q;
  logic [3:0] o_clk_div_q;
  logic [4:0] i_addr;
  logic [7:0] i_wdata, o_rdata_q, i_pin, o_pin, o_pin_oe, o_digital_q, ext, ext_en;
  logic [9:0] o_blank_count_q;
  logic [4:0] offs [6] = '{5'h04, 5'h05, 5'h07, 5'h09, 5'h0B, 5'h0F};
  int         miscompares, total_checks, cycles;
  omg_regs i_omg_regs (.*);
  omg_pin_model i_omg_pin_model (.i_level(o_pin), .i_oe(o_pin_oe), .i_ext(ext), .i_ext_en(ext_en), .o_wire(i_pin));
  //--------------------------------------------------------
  // clock, watchdog and access tasks
  //--------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // a hung bench still reaches the verdict
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      summarize;
    end
  end
  task automatic chk(input string n, input logic [9:0] s, input logic [9:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk("rdata", 10'(o_rdata_q), 10'(e));
  endtask
  task automatic settle;
    repeat (3) @(negedge i_clk);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    i_srst = 1'b1;
    {i_wr, i_rd, i_addr, i_wdata, i_crc_err_flag, i_force_analog_all} = '0;
    ext = 8'hA0;
    ext_en = 8'hF0;
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    foreach (offs[k]) rd(offs[k], 8'h00);
    foreach (offs[k]) wr(offs[k], 8'h3C ^ 8'(k));
    foreach (offs[k]) rd(offs[k], 8'h3C ^ 8'(k));
    wr(5'h06, 8'hFF);
    rd(5'h06, 8'h00);
    $display("registers done");
    wr(5'h04, 8'h21);
    settle;
    chk("auto", 10'(o_auto_mode_q), 10'h001);
    chk("div", 10'(o_clk_div_q), 10'h001);
    wr(5'h04, 8'h1F);
    settle;
    chk("mode", 10'({o_conversion_trigger_mode_q, o_oscillator_choice_q, o_clk_div_q}), 10'h01F);
    wr(5'h05, 8'hFF);
    wr(5'h07, 8'h0F);
    wr(5'h09, 8'h05);
    wr(5'h0B, 8'h03);
    settle;
    chk("oe", 10'(o_pin_oe), 10'h00D);
    chk("pin", 10'(o_pin & o_pin_oe), 10'h001);
    rd(5'h0D, 8'hA3);
    $display("pins done");
    @(posedge i_clk);
    i_crc_err_flag <= 1'b1;
    settle;
    chk("run", 10'({o_seq_run_q, o_pin_oe}), 10'h10D);
    wr(5'h04, 8'h80);
    settle;
    chk("hold", 10'({o_seq_run_q, o_digital_q}), 10'h000);
    rd(5'h18, 8'h02);
    @(posedge i_clk);
    i_crc_err_flag <= 1'b0;
    settle;
    chk("resume", 10'({o_seq_run_q, o_pin_oe}), 10'h10D);
    rd(5'h18, 8'h01);
    @(posedge i_clk);
    i_force_analog_all <= 1'b1;
    settle;
    chk("force", 10'(o_pin_oe), 10'h000);
    rd(5'h0D, 8'h00);
    $display("error and force done");
    wr(5'h0F, 8'h85);
    settle;
    chk("blank", o_blank_count_q, 10'h028);
    wr(5'h0F, 8'h7F);
    settle;
    chk("blank", o_blank_count_q, 10'h07F);
    $display("blanking done");
    summarize;
  end
endmodule // omg_regs_tb
`default_nettype wire
